/* hw/ipdc_ctrl.v */
`timescale 1ns/1ps
`include "ipdc_defs.vh"

// Functional notes
// - drive the two phase PWMs 180 degrees apart.
// - outer PI regulates bus voltage against setpoint, output scales current reference.
// - voltage regulator updates at 2 kHz, gains set for 10 Hz bandwidth.
// - voltage bandwidth stays low to reject twice-line ripple.
// - inner PI drives input current toward the current reference.
// - current regulator updates at 50 kHz, 4 kHz bandwidth, 100 kHz switching.
// - current loop runs far faster than the voltage loop.
// - current regulator output is the shared main duty.
// - on-time varies within a fixed switching period.
// - reference shape comes from the sampled rectified voltage.
// - balance PI takes switch current a minus b against zero.
// - phase a duty is main duty plus correction.
// - phase b duty is main duty minus correction.
// - balance regulator updates at 2 kHz.
// - reference is voltage output times rectified voltage over its peak.
module ipdc_ctrl (
  input  wire        mclk,
  input  wire        rst,
  input  wire [15:0] bus_voltage_setpoint,
  input  wire [15:0] bus_voltage_sample,
  input  wire [15:0] input_current_sample,
  input  wire [15:0] rectified_voltage_sample,
  input  wire [15:0] rectified_voltage_peak,
  input  wire [15:0] switch_current_a,
  input  wire [15:0] switch_current_b,
  output reg         gate_drive_a,
  output reg         gate_drive_b,
  output reg  [15:0] input_current_reference,
  output reg  [9:0]  duty_a_reg,
  output reg  [9:0]  duty_b_reg
);
  // --------------------------------------------------------------------------
  // loop tick generation
  // --------------------------------------------------------------------------
  reg  [9:0]  pwm_cnt_reg;
  reg  [9:0]  i_cnt_reg;
  reg  [15:0] v_cnt_reg;
  wire        pwm_wrap;
  wire        i_tick;
  wire        v_tick;

  assign pwm_wrap = (pwm_cnt_reg == (`IPDC_SW_CYC - 1));
  assign i_tick   = (i_cnt_reg == (`IPDC_ILOOP_CYC - 1));
  assign v_tick   = (v_cnt_reg == (`IPDC_VLOOP_CYC - 1));

  always @(posedge mclk)
  begin
    if (rst)
    begin
      pwm_cnt_reg <= `IPDC_ZERO10;
      i_cnt_reg   <= `IPDC_ZERO10;
      v_cnt_reg   <= `IPDC_ZERO16;
    end
    else
    begin
      pwm_cnt_reg <= pwm_wrap ? `IPDC_ZERO10 : pwm_cnt_reg + 10'h001;
      i_cnt_reg   <= i_tick ? `IPDC_ZERO10 : i_cnt_reg + 10'h001;
      v_cnt_reg   <= v_tick ? `IPDC_ZERO16 : v_cnt_reg + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // voltage and balance regulators
  // --------------------------------------------------------------------------
  wire signed [15:0] v_err;
  wire signed [15:0] b_err;
  wire signed [15:0] v_out;
  wire signed [15:0] dd_out;

  assign v_err = $signed(bus_voltage_setpoint) - $signed(bus_voltage_sample);
  assign b_err = `IPDC_ZERO16 - ($signed(switch_current_a) - $signed(switch_current_b));

  // low gains keep bandwidth well under twice-line ripple
  ipdc_pi #(.KP(`IPDC_VKP), .KI(`IPDC_VKI)) u_vloop (
    .mclk    (mclk),
    .rst     (rst),
    .step    (v_tick),
    .err     (v_err),
    .out_reg (v_out)
  );

  // zero minus (a - b): a heavier phase a must lose duty, else the loop runs away
  ipdc_pi #(.KP(`IPDC_BKP), .KI(`IPDC_BKI)) u_bloop (
    .mclk    (mclk),
    .rst     (rst),
    .step    (v_tick),
    .err     (b_err),
    .out_reg (dd_out)
  );

  // --------------------------------------------------------------------------
  // current reference shaping
  // --------------------------------------------------------------------------
  // divide by peak; a zero peak yields zero shape rather than overflow
  wire [31:0] shape_num;
  wire [15:0] shape_q15;
  wire [31:0] ref_prod;
  wire [15:0] v_pos;
  wire [31:0] shape_quo;

  assign shape_num = {1'b0, rectified_voltage_sample, 15'h0000};
  assign shape_quo = shape_num / {16'h0000, rectified_voltage_peak};
  assign shape_q15 = (rectified_voltage_peak == `IPDC_ZERO16) ? `IPDC_ZERO16 :
                     (shape_quo > `IPDC_POS_MAX) ? 16'h7FFF : shape_quo[15:0];
  assign v_pos     = v_out[15] ? `IPDC_ZERO16 : v_out;
  assign ref_prod  = v_pos * shape_q15;

  always @(posedge mclk)
  begin
    if (rst)
      input_current_reference <= `IPDC_ZERO16;
    else if (i_tick)
      input_current_reference <= ref_prod[30:15];
  end

  // --------------------------------------------------------------------------
  // current regulator
  // --------------------------------------------------------------------------
  wire signed [15:0] i_err;
  wire signed [15:0] d_main;

  assign i_err = $signed(input_current_reference) - $signed(input_current_sample);

  ipdc_pi #(.KP(`IPDC_IKP), .KI(`IPDC_IKI)) u_iloop (
    .mclk    (mclk),
    .rst     (rst),
    .step    (i_tick),
    .err     (i_err),
    .out_reg (d_main)
  );

  // --------------------------------------------------------------------------
  // duty split and clamp
  // --------------------------------------------------------------------------
  wire signed [17:0] d_a_q;
  wire signed [17:0] d_b_q;
  wire [9:0]         d_a_cl;
  wire [9:0]         d_b_cl;

  assign d_a_q = $signed({d_main[15], d_main[15], d_main}) +
                 $signed({dd_out[15], dd_out[15], dd_out});
  assign d_b_q = $signed({d_main[15], d_main[15], d_main}) -
                 $signed({dd_out[15], dd_out[15], dd_out});

  // q15 to counts: scale by period (400) using top bits, then clamp
  function [9:0] to_cnt;
    input signed [17:0] q;
    reg   [31:0]        s;
    begin
      s = 32'h00000000;
      if (q[17])
        to_cnt = `IPDC_ZERO10;
      else
      begin
        s = q[16:0] * `IPDC_SW_CYC;
        to_cnt = (s[27:15] > `IPDC_MAX_DUTY) ? `IPDC_MAX_DUTY : s[24:15];
      end
    end
  endfunction

  assign d_a_cl = to_cnt(d_a_q);
  assign d_b_cl = to_cnt(d_b_q);

  // load only at period wrap so a phase a pulse never glitches; phase b, half a period behind, takes its new duty mid-cycle
  always @(posedge mclk)
  begin
    if (rst)
    begin
      duty_a_reg <= `IPDC_ZERO10;
      duty_b_reg <= `IPDC_ZERO10;
    end
    else if (pwm_wrap)
    begin
      duty_a_reg <= d_a_cl;
      duty_b_reg <= d_b_cl;
    end
  end

  // --------------------------------------------------------------------------
  // interleaved pwm
  // --------------------------------------------------------------------------
  wire [9:0] cnt_b;

  assign cnt_b = (pwm_cnt_reg >= `IPDC_HALF_CNT) ? pwm_cnt_reg - `IPDC_HALF_CNT :
                 pwm_cnt_reg + `IPDC_HALF_CNT;

  // --------------------------------------------------------------------------
  // per-phase compare
  // --------------------------------------------------------------------------
  wire [9:0] phase_cnt [0:1];
  wire [9:0] phase_duty [0:1];
  wire [1:0] phase_on;

  assign phase_cnt[0]  = pwm_cnt_reg;
  assign phase_cnt[1]  = cnt_b;
  assign phase_duty[0] = duty_a_reg;
  assign phase_duty[1] = duty_b_reg;

  genvar ph;
  generate
    for (ph = 0; ph < 2; ph = ph + 1)
    begin : g_phase
      assign phase_on[ph] = (phase_cnt[ph] < phase_duty[ph]);
    end
  endgenerate

  always @(posedge mclk)
  begin
    if (rst)
    begin
      gate_drive_a <= 1'b0;
      gate_drive_b <= 1'b0;
    end
    else
    begin
      gate_drive_a <= phase_on[0];
      gate_drive_b <= phase_on[1];
    end
  end
endmodule

/* hw/ipdc_defs.vh */
`ifndef IPDC_DEFS_VH
`define IPDC_DEFS_VH

// ----------------------------------------------------------------------------
// clock and loop rates
// ----------------------------------------------------------------------------
`define IPDC_CLK_HZ          40000000
`define IPDC_SW_HZ           100000
`define IPDC_ILOOP_HZ        50000
`define IPDC_VLOOP_HZ        2000
`define IPDC_SW_CYC          (`IPDC_CLK_HZ / `IPDC_SW_HZ)
`define IPDC_HALF_CYC        (`IPDC_SW_CYC / 2)
// half period at counter width, keeps phase b math in 10 bits
`define IPDC_HALF_CNT        10'h0C8
`define IPDC_ILOOP_CYC       (`IPDC_CLK_HZ / `IPDC_ILOOP_HZ)
`define IPDC_VLOOP_CYC       (`IPDC_CLK_HZ / `IPDC_VLOOP_HZ)

// ----------------------------------------------------------------------------
// widths and fixed-point formats
// ----------------------------------------------------------------------------
`define IPDC_DW              16
`define IPDC_CW              10
`define IPDC_TW              16
`define IPDC_FRAC            15
`define IPDC_MAX_DUTY        10'h17C
`define IPDC_ZERO16          16'h0000
`define IPDC_ZERO10          10'h000
`define IPDC_ZERO32          32'h00000000
`define IPDC_POS_MAX         32'h00007FFF
`define IPDC_NEG_MAX         32'hFFFF8000

// ----------------------------------------------------------------------------
// default gains, q15
// ----------------------------------------------------------------------------
`define IPDC_VKP             16'h0200
`define IPDC_VKI             16'h0010
`define IPDC_IKP             16'h1000
`define IPDC_IKI             16'h0400
`define IPDC_BKP             16'h0400
`define IPDC_BKI             16'h0040

`endif

/* hw/ipdc_pi.v */
`timescale 1ns/1ps
`include "ipdc_defs.vh"

// ----------------------------------------------------------------------------
// signed q15 pi regulator with saturating integrator
// ----------------------------------------------------------------------------
module ipdc_pi #(
  parameter [15:0] KP = `IPDC_VKP,
  parameter [15:0] KI = `IPDC_VKI
) (
  input  wire               mclk,
  input  wire               rst,
  input  wire               step,
  input  wire signed [15:0] err,
  output reg  signed [15:0] out_reg
);
  reg  signed [31:0] integ_reg;
  wire signed [31:0] p_term;
  wire signed [31:0] i_step;
  wire signed [31:0] integ_sum;
  wire signed [31:0] integ_next;
  wire signed [31:0] total;
  wire signed [31:0] out_sat;

  assign p_term     = ($signed(KP) * err) >>> `IPDC_FRAC;
  assign i_step     = ($signed(KI) * err) >>> `IPDC_FRAC;
  assign integ_sum  = integ_reg + i_step;
  // clamp keeps windup bounded when the duty pins at a limit
  assign integ_next = (integ_sum > $signed(`IPDC_POS_MAX)) ? $signed(`IPDC_POS_MAX) :
                      (integ_sum < $signed(`IPDC_NEG_MAX)) ? $signed(`IPDC_NEG_MAX) :
                      integ_sum;
  assign total      = integ_next + p_term;
  assign out_sat    = (total > $signed(`IPDC_POS_MAX)) ? $signed(`IPDC_POS_MAX) :
                      (total < $signed(`IPDC_NEG_MAX)) ? $signed(`IPDC_NEG_MAX) :
                      total;

  always @(posedge mclk)
  begin
    if (rst)
    begin
      integ_reg <= `IPDC_ZERO32;
      out_reg   <= `IPDC_ZERO16;
    end
    else if (step)
    begin
      integ_reg <= integ_next;
      out_reg   <= out_sat[15:0];
    end
  end
endmodule

/* tb/interleaved_pfc_duty_controller_test.sv */
`timescale 1ns/1ps
module interleaved_pfc_duty_controller_test;
  reg         mclk = 1'b0;
  reg         rst = 1'b1;
  reg  [15:0] setpoint = 16'h0000;
  reg  [15:0] peak = 16'h0000;
  reg  [15:0] skew = 16'h0000;
  wire [15:0] bus_v, i_in, v_rect, i_a, i_b, iref;
  wire        ga, gb;
  wire [9:0]  da, db;
  integer     errors = 0;
  integer     n_checks = 0;
  integer     seed = 32'h2FF42594;
  reg         ref_seen = 1'b0;
  integer     cyc = 0;
  integer     k;
  always #12.5 mclk = ~mclk;
  ipdc_ctrl i_ipdc_ctrl (.mclk(mclk), .rst(rst), .bus_voltage_setpoint(setpoint),
    .bus_voltage_sample(bus_v), .input_current_sample(i_in),
    .rectified_voltage_sample(v_rect), .rectified_voltage_peak(peak),
    .switch_current_a(i_a), .switch_current_b(i_b), .gate_drive_a(ga),
    .gate_drive_b(gb), .input_current_reference(iref), .duty_a_reg(da), .duty_b_reg(db));
  ipdc_stage i_ipdc_stage (.mclk(mclk), .gate_drive_a(ga), .gate_drive_b(gb),
    .skew(skew), .peak(peak), .bus_voltage_sample(bus_v), .input_current_sample(i_in),
    .rectified_voltage_sample(v_rect), .switch_current_a(i_a), .switch_current_b(i_b));
  // ---------------------------------
  // helpers
  // ---------------------------------
  // a heavier phase a must lose duty: 2 means da<db, 1 means da>db
  function [15:0] order_of(input [15:0] s);
    order_of = (s == 16'h0000) ? 16'h0000 : (s[15] ? 16'h0001 : 16'h0002);
  endfunction
  // sticky: reference left zero at least once
  always @(posedge mclk)
    if (iref != 16'h0000 && !rst)
      ref_seen <= 1'b1;
  task check(input [15:0] got, input [15:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task run(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task print_verdict;
  begin
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // guard against a hung run
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 90000)
    begin
      errors = errors + 1;
      print_verdict;
    end
  end
  // ---------------------------------
  // scenarios
  // ---------------------------------
  initial
  begin
    run(6);
    rst <= 1'b0;
    setpoint <= 16'h6000 | ($random(seed) & 16'h0FFF);
    run(1);
    #1;
    check({6'h00, da}, 16'h0000);
    run(1700);
    #1;
    check(iref, 16'h0000);
    check({15'h0000, ref_seen}, 16'h0000);
    $display("test zero_shape done");
    for (k = 0; k < 3; k = k + 1)
    begin
      run(1);
      skew <= (k == 0) ? 16'h0000 : ((k == 1) ? 16'h4000 : 16'hC000);
      peak <= 16'h4000 | ($random(seed) & 16'h3FFF);
      run(22000);
      #1;
      check({14'h0000, da < db, da > db}, order_of(skew));
      $display("test balance %0d done", k);
    end
    check({15'h0000, ref_seen}, 16'h0001);
    run(1);
    rst <= 1'b1;
    run(2);
    #1;
    check({6'h00, da | db}, 16'h0000);
    check(iref, 16'h0000);
    $display("test mid_reset done");
    print_verdict;
  end
endmodule

/* tb/ipdc_ctrl_asserts.sv */
`timescale 1ns/1ps
// ---------------------------------
// port checker
// ---------------------------------
module ipdc_chk (
  input wire        mclk,
  input wire        rst,
  input wire        gate_drive_a,
  input wire        gate_drive_b,
  input wire [15:0] input_current_reference,
  input wire [9:0]  duty_a_reg,
  input wire [9:0]  duty_b_reg
);
  reg [9:0] hi_reg;
  // run length of phase a on-time
  always @(posedge mclk)
    hi_reg <= (gate_drive_a && !rst) ? hi_reg + 10'h001 : 10'h000;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_half;
    ##200 (gate_drive_b == (duty_b_reg != 10'h000));
  endsequence
  a_duty_a_max: assert property (duty_a_reg <= 10'h17C)
    else $error("duty a above max");
  a_duty_b_max: assert property (duty_b_reg <= 10'h17C)
    else $error("duty b above max");
  a_reset_clear: assert property (@(posedge mclk) disable iff (1'b0)
    rst |=> (duty_a_reg == 10'h000 && !gate_drive_a && !gate_drive_b))
    else $error("outputs not cleared by reset");
  a_ref_hold: assert property ($changed(input_current_reference)
    |=> $stable(input_current_reference)[*8]) else $error("reference moved early");
  a_duty_hold: assert property ($changed(duty_a_reg) || $changed(duty_b_reg)
    |=> ($stable(duty_a_reg) && $stable(duty_b_reg))[*8]) else $error("duty moved early");
  a_phase_shift: assert property ($rose(gate_drive_a) |-> s_half)
    else $error("phase b not half a period behind");
  a_period_fixed: assert property ($rose(gate_drive_a)
    |-> ##[400:400] (gate_drive_a == (duty_a_reg != 10'h000))) else $error("period not fixed");
  a_ontime_match: assert property ($fell(gate_drive_a) |-> hi_reg == duty_a_reg)
    else $error("on-time differs from duty a");
endmodule

bind ipdc_ctrl ipdc_chk i_ipdc_chk (.mclk(mclk), .rst(rst), .gate_drive_a(gate_drive_a),
  .gate_drive_b(gate_drive_b), .input_current_reference(input_current_reference),
  .duty_a_reg(duty_a_reg), .duty_b_reg(duty_b_reg));

/* tb/ipdc_stage.sv */
`timescale 1ns/1ps
// ---------------------------------
// crude two-phase boost stage
// ---------------------------------
module ipdc_stage (
  input  wire        mclk,
  input  wire        gate_drive_a,
  input  wire        gate_drive_b,
  input  wire [15:0] skew,
  input  wire [15:0] peak,
  output reg  [15:0] bus_voltage_sample,
  output reg  [15:0] input_current_sample,
  output reg  [15:0] rectified_voltage_sample,
  output reg  [15:0] switch_current_a,
  output reg  [15:0] switch_current_b
);
  reg [15:0] coil_reg = 16'h0000;
  initial
  begin
    bus_voltage_sample = 16'h1000;
    input_current_sample = 16'h0000;
    rectified_voltage_sample = 16'h0000;
    switch_current_a = 16'h0000;
    switch_current_b = 16'h0000;
  end
  // sawtooth stands in for the half sine; capped coil keeps q15 sums in range
  always @(posedge mclk)
  begin
    // extra one-count bleed so the coil never parks at a small value
    coil_reg <= ((gate_drive_a | gate_drive_b) && coil_reg < 16'h3000) ?
      coil_reg + 16'h0004 : coil_reg - (coil_reg >> 8) - {15'h0000, |coil_reg};
    rectified_voltage_sample <= (rectified_voltage_sample + 16'h0020 >= peak) ?
      16'h0000 : rectified_voltage_sample + 16'h0020;
    input_current_sample <= coil_reg;
    bus_voltage_sample <= 16'h1000 + (coil_reg >> 4);
    switch_current_a <= (coil_reg >> 1) + skew;
    switch_current_b <= coil_reg >> 1;
  end
endmodule
